// ---- core/uf_pkg.sv ----
// uart flow-control and enhanced-feature package: offsets, reset values, types
// assumes a single hclk domain; word registers on an ahb-lite slave
// How it works
// - tx flow select bits 3:2 choose characters
// - rx compare bits 1:0 choose characters
// - all select bits zero disables character flow control; auto request/clear-to-send still act
// - enhanced bits writable only while gate set
// - reset clears gated enhanced bits, fractional divisor included, except halt/resume levels (0x0F)
// - special detect matches second pause character
// - compare-two plus special: drop, pause interrupt
// - auto request-to-send follows halt/resume levels
// - auto request only after host asserts it
// - auto clear-to-send high stops transmitter
// - divisor bytes preset at power-up only
// - scratch preset 0xFF at power-up only
// - flow characters cleared at power-up only
// - reset values of channel registers
// - modem deltas clear, levels show inverted inputs
`default_nettype none
package uf_pkg;
   // register byte addresses
   localparam logic [7:0] A_IER   = 8'h00;
   localparam logic [7:0] A_ISR   = 8'h04;
   localparam logic [7:0] A_FCR   = 8'h08;
   localparam logic [7:0] A_LCR   = 8'h0C;
   localparam logic [7:0] A_MCR   = 8'h10;
   localparam logic [7:0] A_LSR   = 8'h14;
   localparam logic [7:0] A_MSR   = 8'h18;
   localparam logic [7:0] A_SPR   = 8'h1C;
   localparam logic [7:0] A_TCR   = 8'h20;
   localparam logic [7:0] A_TLR   = 8'h24;
   localparam logic [7:0] A_FRDY  = 8'h28;
   localparam logic [7:0] A_EFR   = 8'h2C;
   localparam logic [7:0] A_RESUME_CHAR_FIRST  = 8'h30;
   localparam logic [7:0] A_RESUME_CHAR_SECOND  = 8'h34;
   localparam logic [7:0] A_PAUSE_CHAR_FIRST = 8'h38;
   localparam logic [7:0] A_PAUSE_CHAR_SECOND = 8'h3C;
   localparam logic [7:0] A_DLL   = 8'h40;
   localparam logic [7:0] A_DLM   = 8'h44;
   localparam logic [7:0] A_DLD   = 8'h48;
   localparam logic [7:0] A_STS   = 8'h4C;
   localparam logic [7:0] A_MASK  = 8'h50;
   // reset values
   localparam logic [7:0] R_ISR   = 8'h01;
   localparam logic [7:0] R_LCR   = 8'h1D;
   localparam logic [7:0] R_LSR   = 8'h60;
   localparam logic [7:0] R_TCR   = 8'h0F;
   localparam logic [7:0] R_FRDY  = 8'h03;
   localparam logic [7:0] R_SPR   = 8'hFF;
   localparam logic [7:0] R_DLL   = 8'h01;
   localparam logic [7:0] R_DLM   = 8'h00;
   localparam logic [7:0] R_ZERO  = 8'h00;
   // enhanced feature control fields
   localparam int EF_GATE = 4;
   localparam int EF_SPEC = 5;
   localparam int EF_ARTS = 6;
   localparam int EF_ACTS = 7;
   // sticky status bits
   localparam int ST_SPEC  = 0;
   localparam int ST_PAUSE = 1;
   localparam int ST_RESUM = 2;
   localparam int ST_TRIG  = 3;
   localparam int ST_CTS   = 4;
   localparam int ST_MODEM = 5;
   localparam int ST_W     = 6;
   // rx trigger levels when the trigger register's upper nibble is zero
   localparam logic [7:0] TRIG_SEL0 = 8'h08;
   localparam logic [7:0] TRIG_SEL1 = 8'h10;
   localparam logic [7:0] TRIG_SEL2 = 8'h38;
   localparam logic [7:0] TRIG_SEL3 = 8'h3C;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } uf_char_t;
   typedef enum logic [1:0] {
      FC_NONE, FC_SECOND, FC_FIRST, FC_BOTH
   } uf_fsel_t;
endpackage : uf_pkg
`default_nettype wire

// ---- core/uf_flow_ctrl.sv ----
// one uart channel's enhanced features: flow control, gates, special detect
// assumes receiver, transmitter and fifos sit outside on the same hclk;
// modem pins and cts arrive asynchronously and are synchronised here
`default_nettype none
module uf_flow_ctrl
   import uf_pkg::*;
#(
   parameter int LEVEL_W = 7
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              por_n,
   input  wire logic              hsel,
   input  wire logic [7:0]        haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   input  wire uf_char_t          rx_char,
   input  wire logic [LEVEL_W-1:0] rx_level,
   input  wire logic              tx_full,
   input  wire logic              tx_empty,
   input  wire logic              tx_line,
   input  wire logic              flow_tx_ready,
   input  wire logic              cts_n,
   input  wire logic              dsr_n,
   input  wire logic              ri_n,
   input  wire logic              cd_n,
   output uf_char_t               fifo_wr,
   output uf_char_t               flow_tx,
   output logic                   tx_allowed,
   output logic                   serial_tx,
   output logic                   rts_n,
   output logic                   dtr_n,
   output logic                   user_output_two_n,
   output logic                   receive_ready_n,
   output logic                   transmit_ready_n,
   output logic [19:0]            divisor,
   output logic                   int_out,
   output logic                   int_oe
);
   // level comparisons need room for a 60-entry fifo count
   initial begin
      if (LEVEL_W < 6 || LEVEL_W > 8) begin
         $error("LEVEL_W must be 6 to 8");
      end
   end

   logic [7:0] interrupt_enable_reg, fifo_control_reg, line_control_reg;
   logic [7:0] modem_control_reg, line_status_reg, scratch_reg;
   logic [7:0] halt_resume_level_reg, trigger_level_reg;
   logic [7:0] enhanced_feature_control, fractional_divisor_reg;
   logic [7:0] resume_char_first, resume_char_second;
   logic [7:0] pause_char_first, pause_char_second;
   logic [7:0] divisor_low_byte, divisor_high_byte;
   logic [3:0] msr_delta_reg;
   logic [ST_W-1:0] sts_reg, mask_reg, sts_set;
   logic        wr_pend_reg;
   logic [7:0]  wr_addr_reg;
   logic        gate;
   logic [7:0]  wd;
   uf_fsel_t    tx_sel, rx_sel;

   assign gate   = enhanced_feature_control[EF_GATE];
   assign wd     = hwdata[7:0];
   assign tx_sel = uf_fsel_t'(enhanced_feature_control[3:2]);
   assign rx_sel = uf_fsel_t'(enhanced_feature_control[1:0]);

   // pin synchronisers: three stages, change accepted when 2nd and 3rd agree
   logic [3:0] pin_s1, pin_s2, pin_s3, pin_lvl;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1 <= 4'hF;
         pin_s2 <= 4'hF;
         pin_s3 <= 4'hF;
      end else begin
         pin_s1 <= {cd_n, ri_n, dsr_n, cts_n};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   // filtered level moves when last two stages agree
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pin
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pin_lvl[gi] <= 1'b1;
            end else if (pin_s2[gi] == pin_s3[gi]) begin
               pin_lvl[gi] <= pin_s3[gi];
            end
         end
      end
   endgenerate

   // ahb address capture; zero wait states
   logic acc, rd_acc;
   assign acc    = hsel && hready && htrans[1];
   assign rd_acc = acc && !hwrite;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end else begin
         wr_pend_reg <= acc && hwrite;
         if (acc) begin
            wr_addr_reg <= haddr;
         end
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   logic wr;
   assign wr = wr_pend_reg;

   // read mux: unmapped addresses read zero
   logic [7:0] rd_val, isr_val, msr_val, frdy_val;
   assign isr_val  = {2'b00, sts_reg[ST_PAUSE], sts_reg[ST_SPEC], 3'b000,
                      ~|(sts_reg & mask_reg)};
   assign msr_val  = {~pin_lvl[3], ~pin_lvl[2], ~pin_lvl[1], ~pin_lvl[0],
                      msr_delta_reg};
   assign frdy_val = {6'h00, receive_ready_n, ~transmit_ready_n};
   always_comb begin
      rd_val = 8'h00;
      if (haddr == A_IER) begin
         rd_val = interrupt_enable_reg;
      end else if (haddr == A_ISR) begin
         rd_val = isr_val;
      end else if (haddr == A_FCR) begin
         rd_val = fifo_control_reg;
      end else if (haddr == A_LCR) begin
         rd_val = line_control_reg;
      end else if (haddr == A_MCR) begin
         rd_val = modem_control_reg;
      end else if (haddr == A_LSR) begin
         rd_val = line_status_reg;
      end else if (haddr == A_MSR) begin
         rd_val = msr_val;
      end else if (haddr == A_SPR) begin
         rd_val = scratch_reg;
      end else if (haddr == A_TCR) begin
         rd_val = halt_resume_level_reg;
      end else if (haddr == A_TLR) begin
         rd_val = trigger_level_reg;
      end else if (haddr == A_FRDY) begin
         rd_val = frdy_val;
      end else if (haddr == A_EFR) begin
         rd_val = enhanced_feature_control;
      end else if (haddr == A_RESUME_CHAR_FIRST) begin
         rd_val = resume_char_first;
      end else if (haddr == A_RESUME_CHAR_SECOND) begin
         rd_val = resume_char_second;
      end else if (haddr == A_PAUSE_CHAR_FIRST) begin
         rd_val = pause_char_first;
      end else if (haddr == A_PAUSE_CHAR_SECOND) begin
         rd_val = pause_char_second;
      end else if (haddr == A_DLL) begin
         rd_val = divisor_low_byte;
      end else if (haddr == A_DLM) begin
         rd_val = divisor_high_byte;
      end else if (haddr == A_DLD) begin
         rd_val = fractional_divisor_reg;
      end else if (haddr == A_STS) begin
         rd_val = {2'b00, sts_reg};
      end else if (haddr == A_MASK) begin
         rd_val = {2'b00, mask_reg};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_acc) begin
         hrdata <= {24'h000000, rd_val};
      end
   end

   // pin-reset registers; enhanced bits change only while gate is set
   always_ff @(posedge hclk or negedge hresetn or negedge por_n) begin
      if (!hresetn || !por_n) begin
         interrupt_enable_reg     <= R_ZERO;
         fifo_control_reg         <= R_ZERO;
         line_control_reg         <= R_LCR;
         modem_control_reg        <= R_ZERO;
         halt_resume_level_reg    <= R_TCR;
         trigger_level_reg        <= R_ZERO;
         enhanced_feature_control <= R_ZERO;
         fractional_divisor_reg   <= R_ZERO;
         mask_reg                 <= '0;
      end else if (wr) begin
         if (wr_addr_reg == A_IER) begin
            interrupt_enable_reg[3:0] <= wd[3:0];
            if (gate) interrupt_enable_reg[7:4] <= wd[7:4];
         end else if (wr_addr_reg == A_FCR) begin
            fifo_control_reg[3:0] <= wd[3:0];
            fifo_control_reg[7:6] <= wd[7:6];
            if (gate) fifo_control_reg[5:4] <= wd[5:4];
         end else if (wr_addr_reg == A_LCR) begin
            line_control_reg <= wd;
         end else if (wr_addr_reg == A_MCR) begin
            modem_control_reg[4:0] <= wd[4:0];
            if (gate) modem_control_reg[7:5] <= wd[7:5];
         end else if (wr_addr_reg == A_TCR) begin
            if (gate) halt_resume_level_reg <= wd;
         end else if (wr_addr_reg == A_TLR) begin
            if (gate) trigger_level_reg <= wd;
         end else if (wr_addr_reg == A_DLD) begin
            if (gate) fractional_divisor_reg <= wd;
         end else if (wr_addr_reg == A_EFR) begin
            enhanced_feature_control <= wd;
         end else if (wr_addr_reg == A_MASK) begin
            mask_reg <= wd[ST_W-1:0];
         end
      end
   end

   // power-up-only registers: reset pin leaves them
   always_ff @(posedge hclk or negedge por_n) begin
      if (!por_n) begin
         divisor_low_byte   <= R_DLL;
         divisor_high_byte  <= R_DLM;
         scratch_reg        <= R_SPR;
         resume_char_first  <= R_ZERO;
         resume_char_second <= R_ZERO;
         pause_char_first   <= R_ZERO;
         pause_char_second  <= R_ZERO;
      end else if (wr) begin
         if (wr_addr_reg == A_DLL) divisor_low_byte <= wd;
         if (wr_addr_reg == A_DLM) divisor_high_byte <= wd;
         if (wr_addr_reg == A_SPR) scratch_reg <= wd;
         if (wr_addr_reg == A_RESUME_CHAR_FIRST) resume_char_first <= wd;
         if (wr_addr_reg == A_RESUME_CHAR_SECOND) resume_char_second <= wd;
         if (wr_addr_reg == A_PAUSE_CHAR_FIRST) pause_char_first <= wd;
         if (wr_addr_reg == A_PAUSE_CHAR_SECOND) pause_char_second <= wd;
      end
   end

   // receive compare; pairs need char one just before char two
   logic v, m_p1, m_p2, m_r1, m_r2, spec_hit;
   logic last_p1_reg, last_r1_reg, paused_reg;
   logic pause_hit, resume_hit, drop;
   assign v    = rx_char.valid;
   assign m_p1 = rx_char.data == pause_char_first;
   assign m_p2 = rx_char.data == pause_char_second;
   assign m_r1 = rx_char.data == resume_char_first;
   assign m_r2 = rx_char.data == resume_char_second;
   assign spec_hit = v && enhanced_feature_control[EF_SPEC] && m_p2;
   always_comb begin
      pause_hit  = 1'b0;
      resume_hit = 1'b0;
      case (rx_sel)
         FC_FIRST: begin
            pause_hit  = v && m_p1;
            resume_hit = v && m_r1;
         end
         FC_SECOND: begin
            pause_hit  = v && m_p2;
            resume_hit = v && m_r2;
         end
         FC_BOTH: begin
            pause_hit  = v && m_p2 && last_p1_reg;
            resume_hit = v && m_r2 && last_r1_reg;
         end
         default: begin
            pause_hit  = 1'b0;
            resume_hit = 1'b0;
         end
      endcase
   end
   // second pause char under compare-two with special detect is swallowed
   assign drop = spec_hit && rx_sel == FC_SECOND;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_p1_reg <= 1'b0;
         last_r1_reg <= 1'b0;
         paused_reg  <= 1'b0;
         fifo_wr     <= '0;
      end else begin
         if (v) begin
            last_p1_reg <= m_p1;
            last_r1_reg <= m_r1;
         end
         if (rx_sel == FC_NONE) begin
            paused_reg <= 1'b0;
         end else if (pause_hit) begin
            paused_reg <= 1'b1;
         end else if (resume_hit) begin
            paused_reg <= 1'b0;
         end
         // special matches still reach the fifo unless dropped
         fifo_wr.valid <= v && !drop;
         fifo_wr.data  <= rx_char.data;
      end
   end

   // fifo levels in units of four entries
   logic [7:0] lvl, halt_lvl, resume_lvl, trig_lvl;
   logic       at_halt, below_resume, at_resume, at_trig, trig_d_reg;
   assign lvl        = 8'(rx_level);
   assign halt_lvl   = {2'b00, halt_resume_level_reg[3:0], 2'b00};
   assign resume_lvl = {2'b00, halt_resume_level_reg[7:4], 2'b00};
   always_comb begin
      trig_lvl = {2'b00, trigger_level_reg[7:4], 2'b00};
      if (trigger_level_reg[7:4] == 4'h0) begin
         case (fifo_control_reg[7:6])
            2'b00:   trig_lvl = TRIG_SEL0;
            2'b01:   trig_lvl = TRIG_SEL1;
            2'b10:   trig_lvl = TRIG_SEL2;
            default: trig_lvl = TRIG_SEL3;
         endcase
      end
   end
   assign at_halt      = lvl >= halt_lvl;
   assign below_resume = lvl < resume_lvl;
   assign at_resume    = lvl <= resume_lvl;
   assign at_trig      = lvl >= trig_lvl;

   // sticky status: set wins over write-one clear
   logic cts_d_reg;
   assign sts_set[ST_SPEC]  = spec_hit && interrupt_enable_reg[5];
   assign sts_set[ST_PAUSE] = pause_hit;
   assign sts_set[ST_RESUM] = resume_hit;
   assign sts_set[ST_TRIG]  = enhanced_feature_control[EF_ARTS]
                              && at_trig && !trig_d_reg;
   assign sts_set[ST_CTS]   = cts_d_reg != pin_lvl[0];
   assign sts_set[ST_MODEM] = |msr_delta_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sts_reg    <= '0;
         trig_d_reg <= 1'b0;
         cts_d_reg  <= 1'b1;
      end else begin
         trig_d_reg <= at_trig;
         cts_d_reg  <= pin_lvl[0];
         if (wr && wr_addr_reg == A_STS) begin
            sts_reg <= (sts_reg & ~wd[ST_W-1:0]) | sts_set;
         end else begin
            sts_reg <= sts_reg | sts_set;
         end
      end
   end

   // modem deltas: read clears, new change wins
   logic [3:0] lvl_d_reg, delta_set;
   assign delta_set = {lvl_d_reg[3] != pin_lvl[3], !lvl_d_reg[2] && pin_lvl[2],
                       lvl_d_reg[1] != pin_lvl[1], lvl_d_reg[0] != pin_lvl[0]};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         msr_delta_reg <= 4'h0;
         lvl_d_reg     <= 4'hF;
      end else begin
         lvl_d_reg <= pin_lvl;
         if (rd_acc && haddr == A_MSR) begin
            msr_delta_reg <= delta_set;
         end else begin
            msr_delta_reg <= msr_delta_reg | delta_set;
         end
      end
   end

   // flow chars: pause at halt, resume at resume level
   typedef enum logic [1:0] {F_IDLE, F_ONE, F_TWO} uf_fstate_t;
   uf_fstate_t fst_reg;
   logic       sent_pause_reg, send_pause_reg;
   logic [7:0] c1, c2;
   assign c1 = send_pause_reg ? pause_char_first : resume_char_first;
   assign c2 = send_pause_reg ? pause_char_second : resume_char_second;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fst_reg        <= F_IDLE;
         sent_pause_reg <= 1'b0;
         send_pause_reg <= 1'b0;
         flow_tx        <= '0;
      end else begin
         case (fst_reg)
            F_IDLE: begin
               if (tx_sel != FC_NONE && !sent_pause_reg && at_halt) begin
                  send_pause_reg <= 1'b1;
                  sent_pause_reg <= 1'b1;
                  fst_reg        <= F_ONE;
               end else if (tx_sel != FC_NONE && sent_pause_reg && at_resume) begin
                  send_pause_reg <= 1'b0;
                  sent_pause_reg <= 1'b0;
                  fst_reg        <= F_ONE;
               end else if (tx_sel == FC_NONE) begin
                  sent_pause_reg <= 1'b0;
               end
            end
            F_ONE: begin
               flow_tx.valid <= 1'b1;
               flow_tx.data  <= (tx_sel == FC_SECOND) ? c2 : c1;
               if (flow_tx.valid && flow_tx_ready) begin
                  flow_tx.valid <= 1'b0;
                  fst_reg <= (tx_sel == FC_BOTH) ? F_TWO : F_IDLE;
               end
            end
            F_TWO: begin
               flow_tx.valid <= 1'b1;
               flow_tx.data  <= c2;
               if (flow_tx.valid && flow_tx_ready) begin
                  flow_tx.valid <= 1'b0;
                  fst_reg       <= F_IDLE;
               end
            end
            default: fst_reg <= F_IDLE;
         endcase
      end
   end

   // pins, tx gating; reset shows idle levels, interrupt floats
   logic arts_halt_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         arts_halt_reg     <= 1'b0;
         rts_n             <= 1'b1;
         dtr_n             <= 1'b1;
         user_output_two_n <= 1'b1;
         receive_ready_n   <= 1'b1;
         transmit_ready_n  <= 1'b0;
         serial_tx         <= 1'b1;
         int_out           <= 1'b0;
         int_oe            <= 1'b0;
         tx_allowed        <= 1'b0;
         line_status_reg   <= R_LSR;
         divisor           <= 20'h00000;
      end else begin
         if (at_halt) begin
            arts_halt_reg <= 1'b1;
         end else if (below_resume) begin
            arts_halt_reg <= 1'b0;
         end
         // auto mode only acts once the host has asserted the request
         if (enhanced_feature_control[EF_ARTS] && modem_control_reg[1]) begin
            rts_n <= arts_halt_reg;
         end else begin
            rts_n <= ~modem_control_reg[1];
         end
         dtr_n             <= ~modem_control_reg[0];
         user_output_two_n <= ~modem_control_reg[3];
         receive_ready_n   <= lvl == 8'h00;
         transmit_ready_n  <= tx_full;
         serial_tx         <= tx_line;
         int_out           <= |(sts_reg & mask_reg);
         int_oe            <= 1'b1;
         // one cycle behind the pin filter; current char finishes outside
         tx_allowed <= !paused_reg && !(enhanced_feature_control[EF_ACTS]
                       && pin_lvl[0]);
         line_status_reg <= {1'b0, tx_empty, tx_empty, 4'h0, !receive_ready_n};
         divisor <= {divisor_high_byte, divisor_low_byte,
                     fractional_divisor_reg[3:0]};
      end
   end
endmodule : uf_flow_ctrl
`default_nettype wire

// ---- sim/uf_flow_ctrl_checker.sv ----
// checker: flow-control port relations
// assumes one hclk domain; bound to every uf_flow_ctrl
`default_nettype none
module uf_checker
   import uf_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        por_n,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire uf_char_t    rx_char,
   input wire uf_char_t    fifo_wr,
   input wire uf_char_t    flow_tx,
   input wire logic        flow_tx_ready,
   input wire logic        tx_line,
   input wire logic        serial_tx,
   input wire logic        rts_n,
   input wire logic        dtr_n,
   input wire logic        user_output_two_n,
   input wire logic        receive_ready_n,
   input wire logic        transmit_ready_n,
   input wire logic        int_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_bus_okay: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h0)
      else $error("bus answer not okay");
   a_fifo_source: assert property (fifo_wr.valid |-> $past(rx_char.valid) && fifo_wr.data == $past(rx_char.data))
      else $error("stray fifo write");
   a_flow_hold: assert property (flow_tx.valid && !flow_tx_ready |=> flow_tx.valid && $stable(flow_tx.data))
      else $error("flow char dropped");
   a_flow_release: assert property (flow_tx.valid && flow_tx_ready |=> !flow_tx.valid)
      else $error("flow char held");
   a_tx_follow: assert property ($past(hresetn) |-> serial_tx == $past(tx_line))
      else $error("serial line lag");
   a_int_drive: assert property ($past(hresetn) |-> int_oe)
      else $error("int not driven");
   a_release_quiet: assert property ($rose(hresetn) |-> !int_oe && !fifo_wr.valid && !flow_tx.valid)
      else $error("busy at release");
   a_reset_pins: assert property (@(posedge hclk) disable iff (!por_n) !hresetn |-> rts_n && dtr_n
      && user_output_two_n && receive_ready_n && serial_tx && !transmit_ready_n && !int_oe)
      else $error("reset pins wrong");
endmodule : uf_checker
bind uf_flow_ctrl uf_checker chk_i (.*);
`default_nettype wire

// ---- sim/uf_remote.sv ----
// remote uart model: sends rx chars, takes flow chars slowly
// assumes the bench calls send() right after a rising edge
`default_nettype none
module uf_remote
   import uf_pkg::*;
(
   input wire logic     hclk,
   input wire uf_char_t flow_tx,
   output var logic     flow_tx_ready,
   output var uf_char_t rx_char,
   output var logic [7:0] last_flow
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      flow_tx_ready = 1'b0;
      rx_char = '0;
      last_flow = 8'h00;
   end
   // ready every other cycle: sender must hold its char
   always @(posedge hclk) begin
      flow_tx_ready <= ~flow_tx_ready;
      if (flow_tx.valid && flow_tx_ready) last_flow <= flow_tx.data;
   end
   // one char pulse; data inverted afterwards so stale data never matches
   task send(input logic [7:0] c);
      rx_char <= {1'b1, c};
      @(posedge hclk);
      rx_char <= {1'b0, ~c};
   endtask : send
endmodule : uf_remote
`default_nettype wire

// ---- sim/uf_flow_ctrl_tb_top.sv ----
// bench: register, flow-control and special-char tests over ahb-lite
// assumes remote model for the serial side, modem pins idle high
`default_nettype none
module uf_flow_ctrl_tb_top
   import uf_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic hclk, hresetn, por_n, hsel, hwrite, hreadyout, tx_line, cts_n, rts_n, tx_allowed, int_out, flow_tx_ready;
   logic [7:0] haddr, last_flow;
   logic [1:0] htrans;
   logic [31:0] hwdata, hrdata;
   logic [6:0] rx_level;
   logic [2:0] mdm;
   uf_char_t rx_char, fifo_wr, flow_tx;
   int err_count, comparisons;
   logic [7:0] ra [20] = '{A_IER, A_ISR, A_FCR, A_LCR, A_MCR, A_LSR, A_MSR, A_SPR, A_TCR, A_TLR, A_FRDY, A_EFR,
      A_RESUME_CHAR_FIRST, A_RESUME_CHAR_SECOND, A_PAUSE_CHAR_FIRST, A_PAUSE_CHAR_SECOND, A_DLL, A_DLM, A_DLD, 8'h60};
   logic [7:0] rv [20] = '{0, R_ISR, 0, R_LCR, 0, R_LSR, 0, R_SPR, R_TCR, 0, R_FRDY, 0, 0, 0, 0, 0, R_DLL, R_DLM, 0, 0};
   uf_flow_ctrl DUT (.hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .rx_char, .rx_level, .tx_full(1'b0), .tx_empty(1'b1),
      .tx_line, .flow_tx_ready, .cts_n, .dsr_n(mdm[0]), .ri_n(mdm[1]), .cd_n(mdm[2]), .fifo_wr, .flow_tx,
      .tx_allowed, .serial_tx(), .rts_n, .dtr_n(), .user_output_two_n(), .receive_ready_n(),
      .transmit_ready_n(), .divisor(), .int_out, .int_oe());
   uf_remote R (.hclk, .flow_tx, .flow_tx_ready, .rx_char, .last_flow);
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   // toggling line exercises serial delay check
   always @(posedge hclk) tx_line <= ~tx_line;
   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk
   // single word transfer; waits on hready
   task bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] e);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      if (!w) chk(hrdata, e, "register read");
   endtask : bus
   task complete_run;
      $display("compares %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   initial begin
      #20us;
      err_count++;
      complete_run();
   end
   initial begin
      {hresetn, por_n, hsel, hwrite, tx_line, cts_n, haddr, htrans, hwdata, rx_level} = '0;
      {cts_n, mdm} = 4'hF;
      repeat (2) @(posedge hclk);
      {hresetn, por_n} <= 2'b11;
      @(posedge hclk);
      for (int i = 0; i < 20; i++) bus(ra[i], 0, 0, rv[i]);
      bus(A_SPR, 1, 8'h5A, 0);
      bus(A_DLL, 1, 8'h07, 0);
      bus(A_PAUSE_CHAR_SECOND, 1, 8'hA5, 0);
      bus(A_EFR, 1, 8'h10, 0);
      bus(A_TCR, 1, 8'h12, 0);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(A_SPR, 0, 0, 8'h5A);
      bus(A_DLL, 0, 0, 8'h07);
      bus(A_PAUSE_CHAR_SECOND, 0, 0, 8'hA5);
      bus(A_TCR, 0, 0, R_TCR);
      bus(A_TCR, 1, 8'h12, 0);
      bus(A_TCR, 0, 0, R_TCR);
      bus(A_EFR, 1, 8'h10, 0);
      bus(A_TCR, 1, 8'h12, 0);
      bus(A_TCR, 0, 0, 8'h12);
      bus(A_IER, 1, 8'h20, 0);
      $display("test registers ended");
      chk(tx_allowed, 1, "tx stopped");
      bus(A_EFR, 1, 8'h90, 0);
      mdm <= 3'h2;
      repeat (6) @(posedge hclk);
      chk(tx_allowed, 0, "cts high");
      cts_n <= 1'b0;
      repeat (6) @(posedge hclk);
      chk(tx_allowed, 1, "cts low");
      bus(A_EFR, 1, 8'h10, 0);
      bus(A_PAUSE_CHAR_FIRST, 1, 8'h13, 0);
      bus(A_RESUME_CHAR_FIRST, 1, 8'h11, 0);
      bus(A_MCR, 1, 8'h02, 0);
      bus(A_EFR, 1, 8'h58, 0);
      chk(rts_n, 0, "rts not host driven");
      rx_level <= 7'd8;
      repeat (10) @(posedge hclk);
      chk(rts_n, 1, "rts not halted");
      chk(last_flow, 8'h13, "pause char");
      rx_level <= 7'd3;
      repeat (10) @(posedge hclk);
      chk(rts_n, 0, "rts not resumed");
      chk(last_flow, 8'h11, "resume char");
      $display("test hardware flow ended");
      bus(A_MSR, 0, 0, 8'hBB);
      bus(A_EFR, 1, 8'h10, 0);
      bus(A_EFR, 1, 8'h31, 0);
      bus(A_STS, 1, 8'hFF, 0);
      R.send(8'hA5);
      #1 chk(fifo_wr.valid, 0, "pause char stored");
      @(posedge hclk);
      bus(A_STS, 0, 0, 8'h03);
      chk(int_out, 0, "masked irq seen");
      bus(A_MASK, 1, 8'h03, 0);
      @(posedge hclk);
      #1 chk(int_out, 1, "irq missing");
      @(posedge hclk);
      bus(A_STS, 1, 8'h03, 0);
      @(posedge hclk);
      #1 chk(int_out, 0, "irq stuck");
      @(posedge hclk);
      bus(A_EFR, 1, 8'h10, 0);
      bus(A_EFR, 1, 8'h32, 0);
      R.send(8'hA5);
      #1 chk(fifo_wr, {1'b1, 8'hA5}, "special lost");
      $display("test special char ended");
      complete_run();
   end
endmodule : uf_flow_ctrl_tb_top
`default_nettype wire
